// ---- rtl/ecm_pkg.sv ----
// shared constants and carriers of the per-channel maintenance block
// assumes a 200 MHz core clock and 32-channel frames of 8-bit words
package ecm_pkg;
	// core clock and tick timing
	localparam int CLK_MHZ     = 200;
	localparam int TICK_US     = 1000;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
	// frame alignment error indicator
	localparam logic [6:0] FAS_PATTERN = 7'h1b;
	localparam int ERR_FLAG_BIT = 5;
	localparam int ERR_GUARD_MS = 128;
	localparam int ERR_GUARD_TICKS = ERR_GUARD_MS * 1000 / TICK_US;
	// signalling hold-over and debounce
	localparam int HOLD_MS     = 6;
	localparam int HOLD_TICKS  = HOLD_MS * 1000 / TICK_US;
	localparam int MF_US       = 2000;
	localparam int DEB_MIN_US  = 6000;
	localparam int DEB_SIGHT   = (DEB_MIN_US + MF_US - 1) / MF_US;
	// channel numbers
	localparam logic [4:0] CH_CAS    = 5'h10;
	localparam logic [4:0] CH_DEBCTL = 5'h0f;
	localparam logic [4:0] CH_FAS_IN = 5'h10;
	localparam logic [4:0] CH_NFAS_IN = 5'h11;
	localparam logic [4:0] CH_MASTER_STATUS_ONE   = 5'h12;
	localparam logic [4:0] CH_PSW    = 5'h13;
	localparam logic [4:0] CH_CRC    = 5'h14;
	localparam logic [4:0] CH_MASTER_STATUS_TWO   = 5'h15;
	// register offsets and fields
	localparam logic [3:0] REG_CTRL  = 4'h0;
	localparam logic [3:0] REG_STAT  = 4'h1;
	localparam logic [3:0] REG_IRQST = 4'h2;
	localparam logic [3:0] REG_IRQMS = 4'h3;
	localparam int IRQ_ERR  = 0;
	localparam int IRQ_LOSS = 1;
	localparam int IRQ_SIG  = 2;
	localparam logic [3:0] SIG_IDLE = 4'hf;
	// received timeslot from the framer
	typedef struct packed {
		logic       valid;
		logic [4:0] num;
		logic [7:0] data;
		logic [3:0] frame;
		logic       align;
	} ecm_rxslot_s;
	// transmit timeslot towards the line coder
	typedef struct packed {
		logic       valid;
		logic [4:0] num;
		logic [7:0] data;
	} ecm_txslot_s;
	// status words made by neighbouring blocks
	typedef struct packed {
		logic [7:0] master_status_one;
		logic [7:0] phase_status_word;
		logic [7:0] crc;
		logic [7:0] master_status_two;
	} ecm_stat_s;
endpackage

// ---- rtl/ecm_gain_rom.sv ----
// digital attenuation of one companded 8-bit sample
// purely combinational; the caller registers the result
`timescale 1ns/1ps
module ecm_gain_rom (
	input  wire logic [7:0] sampleIn,
	input  wire logic [2:0] gainCode,
	output logic      [7:0] sampleOut
);
	// q8 gain factor: 0 dB down to -6 dB, code 7 is +1 dB
	function automatic logic [8:0] gainQ8(input logic [2:0] c);
		case (c)
			3'h0: gainQ8 = 9'h100;
			3'h1: gainQ8 = 9'h0e4;
			3'h2: gainQ8 = 9'h0cb;
			3'h3: gainQ8 = 9'h0b5;
			3'h4: gainQ8 = 9'h0a1;
			3'h5: gainQ8 = 9'h090;
			3'h6: gainQ8 = 9'h080;
			default: gainQ8 = 9'h11f;
		endcase
	endfunction

	logic [7:0]  x;
	logic [14:0] mag;
	logic [23:0] prod;
	logic [14:0] scl;
	logic [2:0]  ex;

	// expand, scale, saturate and compress again
	always_comb begin
		x    = sampleIn ^ 8'h55;
		mag  = (x[6:4] == 3'h0) ? {7'h00, x[3:0], 4'h8} :
			15'(({11'h000, x[3:0], 4'h8} + 15'h0100) << (x[6:4] - 3'h1));
		prod = mag * gainQ8(gainCode);
		scl  = (prod[23:8] > 16'h7dff) ? 15'h7dff : prod[22:8];
		ex   = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (scl >= (15'h0080 << i))
				ex = 3'(i);
		end
		if (gainCode == 3'h0)
			sampleOut = sampleIn; // unity keeps the sample bit-exact
		else if (ex == 3'h0)
			sampleOut = {x[7], 3'h0, scl[7:4]} ^ 8'h55;
		else
			sampleOut = {x[7], ex, 4'(scl >> (ex + 3'h3))} ^ 8'h55;
	end
endmodule // ecm_gain_rom

// ---- rtl/ecm_channel_maint.sv ----
// per-channel maintenance: error toggle, attenuation, signalling ram,
// serial backplane streams. assumes framer logic on clk and a sampled
// backplane bit clock with an active-low frame pulse.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - toggle error flag per sixteen errored FAS
// - error flag toggles at most once per 128 ms
// - compare alignment word against 0011011
// - attenuate every tx and rx sample except channels 0 and 16
// - control channel n governs data n+1
// - signalling ram, valid when synced and during hold-over
// - hold signalling 6 ms after sync loss, unless all four debounce-disable bits are set
// - debounce delays changes 6 to 8 ms
// - debounce per bit from control ch15
// - drive status stream in unused channels
// - status words in fixed consecutive order
// - device fills the signalling slot
// - phase, crc, status two on 19-21
// - disable bit one turns debounce off
module ecm_channel_maint
	import ecm_pkg::*;
#(
	parameter int TICK_LEN = ecm_pkg::TICK_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              busClk,
	input  wire logic              busFrame_n,
	input  wire logic              controlInStreamA,
	input  wire logic              controlInStreamB,
	input  wire logic              dataInStream,
	output logic                   statusOutStream,
	output logic                   dataOutStream,
	input  wire ecm_pkg::ecm_rxslot_s rxSlot,
	input  wire logic              frameSync,
	input  wire ecm_pkg::ecm_stat_s statWords,
	output ecm_pkg::ecm_txslot_s   txSlot,
	input  wire logic [3:0]        regAddr,
	input  wire logic [7:0]        regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [7:0]        regRdData,
	output logic                   irq
);
	import ecm_pkg::*;

	typedef struct packed {
		logic [4:0]            pinS1;
		logic [4:0]            pinS2;
		logic                  clkPrev;
		logic [7:0]            pos;
		logic [7:0]            shA;
		logic [7:0]            shB;
		logic [7:0]            shD;
		logic [7:0]            outS;
		logic [7:0]            outD;
		logic [31:0][7:0]      ctrlA;
		logic [15:0][7:0]      casTx;
		logic [7:0]            fasWord;
		logic [7:0]            nfasWord;
		logic [3:0]            txFrame;
		ecm_txslot_s           tx;
		logic [31:0][7:0]      rxBuf;
		logic [31:0][3:0]      sig;
		logic [31:0][3:0]      cand;
		logic [31:0][3:0][1:0] deb;
		logic [3:0]            errCnt;
		logic                  errPend;
		logic                  errFlag;
		logic                  guardBusy;
		logic [7:0]            guardMs;
		logic [19:0]           msCnt;
		logic [2:0]            holdMs;
		logic                  holdActive;
		logic                  sigValid;
		logic                  syncPrev;
		logic                  ccsSel;
		logic [2:0]            irqSt;
		logic [2:0]            irqMask;
		logic                  irq;
		logic [7:0]            rdData;
	} ecm_state_s;

	ecm_state_s st_ff;
	ecm_state_s nxt_st;

	logic [7:0] txGainIn;
	logic [7:0] txGainOut;
	logic [7:0] rxGainOut;
	logic [4:0] txCh;
	logic       loadNow;
	logic [4:0] loadCh;
	logic       sigEvt;

	// signalling nibble shown on the stream; idle ones when not valid
	function automatic logic [3:0] sigOut(input ecm_state_s s,
		input logic [4:0] c);
		sigOut = s.sigValid ? s.sig[c] : SIG_IDLE;
	endfunction

	// byte of the status stream for one channel
	function automatic logic [7:0] statusByte(input ecm_state_s s,
		input logic [4:0] c, input ecm_stat_s w);
		logic [7:0] m1;
		m1 = w.master_status_one;
		m1[ERR_FLAG_BIT] = s.errFlag;
		if (c < CH_CAS)
			statusByte = {sigOut(s, c), sigOut(s, c + CH_CAS)};
		else if (c == CH_MASTER_STATUS_ONE)
			statusByte = m1;
		else if (c == CH_PSW)
			statusByte = w.phase_status_word;
		else if (c == CH_CRC)
			statusByte = w.crc;
		else if (c == CH_MASTER_STATUS_TWO)
			statusByte = w.master_status_two;
		else
			statusByte = 8'h00; // unused channels still driven
	endfunction

	// input byte completing on this edge and its channel
	assign txGainIn = {st_ff.shD[6:0], st_ff.pinS2[0]};
	assign txCh     = st_ff.pos[7:3];
	assign sigEvt   = rxSlot.valid && rxSlot.num == CH_CAS &&
		rxSlot.frame != 4'h0 && frameSync && st_ff.sigValid;

	// tx gain from the previous channel's control word
	ecm_gain_rom u_txGain (
		.sampleIn  (txGainIn),
		.gainCode  (st_ff.ctrlA[5'(txCh - 5'h01)][2:0]),
		.sampleOut (txGainOut)
	);

	// rx gain likewise from the control word one channel lower
	ecm_gain_rom u_rxGain (
		.sampleIn  (rxSlot.data),
		.gainCode  (st_ff.ctrlA[5'(rxSlot.num - 5'h01)][5:3]),
		.sampleOut (rxGainOut)
	);

	// all next-state logic
	always_comb begin
		logic       edgeNow;
		logic       tick;
		logic [7:0] p;
		logic [7:0] q;
		logic [7:0] bA;
		logic [7:0] bB;
		logic [4:0] c;
		logic [4:0] sc;
		logic [3:0] nib;
		logic [2:0] evt;
		edgeNow = 1'b0;
		tick    = 1'b0;
		p       = 8'h00;
		q       = 8'h00;
		bA      = 8'h00;
		bB      = 8'h00;
		c       = 5'h00;
		sc      = 5'h00;
		nib     = 4'h0;
		evt     = 3'h0;
		nxt_st  = st_ff;
		loadNow = 1'b0;
		loadCh  = 5'h00;
		nxt_st.tx.valid = 1'b0;

		// second stage only reads the first; edges use the second
		nxt_st.pinS1 = {busClk, busFrame_n, controlInStreamA,
			controlInStreamB, dataInStream};
		nxt_st.pinS2 = st_ff.pinS1;
		nxt_st.clkPrev = st_ff.pinS2[4];
		edgeNow = st_ff.pinS2[4] && !st_ff.clkPrev;

		// millisecond tick paces the guard and hold-over timers
		tick = (st_ff.msCnt == 20'(TICK_LEN - 1));
		nxt_st.msCnt = tick ? 20'h00000 : 20'(st_ff.msCnt + 20'h00001);

		// backplane bit: frame pulse marks bit 7 of channel 0
		if (edgeNow) begin
			p = st_ff.pinS2[3] ? st_ff.pos : 8'h00;
			bA = {st_ff.shA[6:0], st_ff.pinS2[2]};
			bB = {st_ff.shB[6:0], st_ff.pinS2[1]};
			nxt_st.shA = bA;
			nxt_st.shB = bB;
			nxt_st.shD = txGainIn;
			if (p[2:0] == 3'h7) begin
				c = p[7:3];
				nxt_st.ctrlA[c] = bA;
				if (c < CH_CAS)
					nxt_st.casTx[c[3:0]] = bB;
				else if (c == CH_FAS_IN)
					nxt_st.fasWord = bB;
				else if (c == CH_NFAS_IN)
					nxt_st.nfasWord = bB;
				nxt_st.tx.valid = 1'b1;
				nxt_st.tx.num = c;
				if (c == 5'h00)
					nxt_st.tx.data = st_ff.txFrame[0] ? st_ff.nfasWord :
						st_ff.fasWord;
				else if (c == CH_CAS && !st_ff.ccsSel)
					nxt_st.tx.data = st_ff.casTx[st_ff.txFrame];
				else if (c == CH_CAS)
					nxt_st.tx.data = txGainIn; // ccs rides a data channel
				else
					nxt_st.tx.data = txGainOut;
				if (c == 5'h1f)
					nxt_st.txFrame = 4'(st_ff.txFrame + 4'h1);
			end
			// outputs lead the sampled position by one bit
			q = 8'(p + 8'h01);
			nxt_st.pos = q;
			if (q[2:0] == 3'h0) begin
				loadNow = 1'b1;
				loadCh = q[7:3];
				nxt_st.outS = statusByte(st_ff, q[7:3], statWords);
				nxt_st.outD = st_ff.rxBuf[q[7:3]];
			end else begin
				nxt_st.outS = {st_ff.outS[6:0], 1'b0};
				nxt_st.outD = {st_ff.outD[6:0], 1'b0};
			end
		end

		// received timeslots from the framer
		if (rxSlot.valid) begin
			if (rxSlot.num == 5'h00 || rxSlot.num == CH_CAS)
				nxt_st.rxBuf[rxSlot.num] = rxSlot.data;
			else
				nxt_st.rxBuf[rxSlot.num] = rxGainOut;
			if (rxSlot.num == 5'h00 && rxSlot.align && frameSync &&
				rxSlot.data[6:0] != FAS_PATTERN) begin
				nxt_st.errCnt = 4'(st_ff.errCnt + 4'h1);
				if (st_ff.errCnt == 4'hf)
					nxt_st.errPend = 1'b1;
			end
		end

		// signalling ram with per-bit debounce, two channels per slot
		if (sigEvt) begin
			for (int k = 0; k < 2; k++) begin
				sc  = (k == 0) ? {1'b0, rxSlot.frame} :
					{1'b1, rxSlot.frame};
				nib = (k == 0) ? rxSlot.data[7:4] : rxSlot.data[3:0];
				for (int b = 0; b < 4; b++) begin
					// nibble bit 3 is A, steered by control bit 0
					if (st_ff.ctrlA[CH_DEBCTL][3 - b]) begin
						nxt_st.sig[sc][b]  = nib[b];
						nxt_st.cand[sc][b] = nib[b];
						nxt_st.deb[sc][b]  = 2'h0;
					end else if (nib[b] != st_ff.cand[sc][b]) begin
						nxt_st.cand[sc][b] = nib[b];
						nxt_st.deb[sc][b]  = 2'h0;
					end else if (st_ff.cand[sc][b] != st_ff.sig[sc][b])
						begin
						if (st_ff.deb[sc][b] == 2'(DEB_SIGHT - 1)) begin
							nxt_st.sig[sc][b] = st_ff.cand[sc][b];
							nxt_st.deb[sc][b] = 2'h0;
						end else
							nxt_st.deb[sc][b] = 2'(st_ff.deb[sc][b] + 2'h1);
					end
					if (nxt_st.sig[sc][b] != st_ff.sig[sc][b])
						evt[IRQ_SIG] = 1'b1;
				end
			end
		end

		// error flag waits for the guard interval to run out
		if (tick && st_ff.guardBusy) begin
			nxt_st.guardMs = 8'(st_ff.guardMs + 8'h01);
			if (st_ff.guardMs == 8'(ERR_GUARD_TICKS - 1))
				nxt_st.guardBusy = 1'b0;
		end
		if (st_ff.errPend && !st_ff.guardBusy) begin
			nxt_st.errFlag   = !st_ff.errFlag;
			nxt_st.errPend   = 1'b0;
			nxt_st.guardBusy = 1'b1;
			nxt_st.guardMs   = 8'h00;
			evt[IRQ_ERR]     = 1'b1;
		end

		// sync tracking and signalling hold-over
		nxt_st.syncPrev = frameSync;
		if (frameSync && !st_ff.syncPrev) begin
			nxt_st.sigValid   = 1'b1;
			nxt_st.holdActive = 1'b0;
		end else if (!frameSync && st_ff.syncPrev) begin
			evt[IRQ_LOSS] = 1'b1;
			if (st_ff.ctrlA[CH_DEBCTL][3:0] != 4'hf) begin
				nxt_st.holdActive = 1'b1;
				nxt_st.holdMs     = 3'h0;
			end else
				nxt_st.sigValid = 1'b0;
		end else if (st_ff.holdActive && tick) begin
			nxt_st.holdMs = 3'(st_ff.holdMs + 3'h1);
			if (st_ff.holdMs == 3'(HOLD_TICKS - 1)) begin
				nxt_st.holdActive = 1'b0;
				nxt_st.sigValid   = 1'b0;
			end
		end

		// register port; a set in the clearing cycle survives
		nxt_st.rdData = 8'h00;
		if (regWr) begin
			case (regAddr)
				REG_CTRL:  nxt_st.ccsSel = regWrData[0];
				REG_IRQST: nxt_st.irqSt = st_ff.irqSt & ~regWrData[2:0];
				REG_IRQMS: nxt_st.irqMask = regWrData[2:0];
				default:   nxt_st.ccsSel = st_ff.ccsSel;
			endcase
		end
		nxt_st.irqSt = nxt_st.irqSt | evt;
		if (regRd) begin
			case (regAddr)
				REG_CTRL:  nxt_st.rdData = {7'h00, st_ff.ccsSel};
				REG_STAT:  nxt_st.rdData = {4'h0, st_ff.sigValid,
					st_ff.holdActive, st_ff.errFlag, frameSync};
				REG_IRQST: nxt_st.rdData = {5'h00, st_ff.irqSt};
				REG_IRQMS: nxt_st.rdData = {5'h00, st_ff.irqMask};
				default:   nxt_st.rdData = 8'h00;
			endcase
		end
		nxt_st.irq = |(nxt_st.irqSt & nxt_st.irqMask);
	end

	// single state register; reset clears everything
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign statusOutStream = st_ff.outS[7];
	assign dataOutStream   = st_ff.outD[7];
	assign txSlot          = st_ff.tx;
	assign regRdData       = st_ff.rdData;
	assign irq             = st_ff.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_err_toggle_cause: assert property (
		$changed(st_ff.errFlag) |-> $past(st_ff.errPend) &&
			!$past(st_ff.guardBusy))
		else $error("error flag toggled without 16 errors");
	a_err_guard_hold: assert property (
		st_ff.guardBusy |=> !$changed(st_ff.errFlag))
		else $error("error flag toggled inside guard interval");
	a_fas_count: assert property (
		rxSlot.valid && rxSlot.num == 5'h00 && rxSlot.align && frameSync
		&& rxSlot.data[6:0] != FAS_PATTERN
		|=> st_ff.errCnt == 4'($past(st_ff.errCnt) + 4'h1))
		else $error("errored alignment word not counted");
	a_fas_ignore: assert property (
		rxSlot.valid && (!frameSync || !rxSlot.align)
		|=> st_ff.errCnt == $past(st_ff.errCnt))
		else $error("error counted outside synced alignment frame");
	a_deb_bypass: assert property (
		sigEvt && st_ff.ctrlA[CH_DEBCTL][0]
		|=> st_ff.sig[$past(rxSlot.frame)][3] == $past(rxSlot.data[7]))
		else $error("debounce-off bit not passed straight");
	a_deb_restart: assert property (
		sigEvt && !st_ff.ctrlA[CH_DEBCTL][0] &&
		rxSlot.data[7] != st_ff.cand[rxSlot.frame][3]
		|=> st_ff.deb[$past(rxSlot.frame)][3] == 2'h0)
		else $error("debounce timer not restarted");
	a_deb_accept: assert property (
		$changed(st_ff.sig[3][3]) && !$past(st_ff.ctrlA[CH_DEBCTL][0])
		|-> $past(st_ff.deb[3][3]) == 2'(DEB_SIGHT - 1))
		else $error("signalling change accepted too early");
	a_hold_time: assert property (
		$fell(st_ff.holdActive) && !st_ff.sigValid
		|-> $past(st_ff.holdMs) == 3'(HOLD_TICKS - 1))
		else $error("hold-over ended at wrong time");
	a_status_psw: assert property (
		loadNow && loadCh == CH_PSW |=> st_ff.outS == $past(statWords.phase_status_word))
		else $error("phase status word not on its channel");
	a_unused_zero: assert property (
		loadNow && loadCh > CH_MASTER_STATUS_TWO |=> st_ff.outS == 8'h00)
		else $error("unused status channel not driven low");
	a_tx_cas: assert property (
		st_ff.tx.valid && st_ff.tx.num == CH_CAS && !$past(st_ff.ccsSel)
		|-> st_ff.tx.data == st_ff.casTx[st_ff.txFrame])
		else $error("signalling slot not filled by device");

	c_err_toggle: cover property ($changed(st_ff.errFlag));
	c_hold_end:   cover property ($fell(st_ff.holdActive));
	c_sig_accept: cover property ($changed(st_ff.sig[3][3]));
	c_tx_cas:     cover property (st_ff.tx.valid && st_ff.tx.num == CH_CAS);
endmodule // ecm_channel_maint

// ---- test/ecm_backplane_model.sv ----
// backplane switch model: bit clock, frame pulse, control and data
// streams out, status and data streams captured per channel.
// assumes the bench fills ctlA, ctlB and dataIn by hierarchical name.
`timescale 1ns/1ps
module ecm_backplane_model (
	output logic      busClk,
	output logic      busFrame_n,
	output logic      controlInStreamA,
	output logic      controlInStreamB,
	output logic      dataInStream,
	input  wire logic statusOutStream,
	input  wire logic dataOutStream
);
	logic [7:0] ctlA   [32];
	logic [7:0] ctlB   [32];
	logic [7:0] dataIn [32];
	logic [7:0] statCh [32];
	logic [7:0] dataCh [32];
	logic [7:0] pos;
	logic [6:0] statSh;
	logic [6:0] dataSh;
	int         frames;

	// free-running bit clock, 80 ns period, offset so its edges never coincide with clk edges
	initial begin
		pos = 8'h00;
		frames = 0;
		busFrame_n = 1'b1;
		controlInStreamA = 1'b0;
		controlInStreamB = 1'b0;
		dataInStream = 1'b0;
		busClk = 1'b0;
		#13;
		forever #40 busClk = ~busClk;
	end

	// launch on the falling edge so bits are settled when sampled
	always @(negedge busClk) begin
		busFrame_n       <= (pos != 8'h00);
		controlInStreamA <= ctlA[pos[7:3]][~pos[2:0]];
		controlInStreamB <= ctlB[pos[7:3]][~pos[2:0]];
		dataInStream     <= dataIn[pos[7:3]][~pos[2:0]];
	end

	// capture msb first; a byte is kept once its last bit lands
	always @(posedge busClk) begin
		statSh <= {statSh[5:0], statusOutStream};
		dataSh <= {dataSh[5:0], dataOutStream};
		if (pos[2:0] == 3'h7) begin
			statCh[pos[7:3]] <= {statSh, statusOutStream};
			dataCh[pos[7:3]] <= {dataSh, dataOutStream};
		end
		if (pos == 8'hff)
			frames <= frames + 1;
		pos <= pos + 8'h01;
	end
endmodule // ecm_backplane_model

// ---- test/tb.sv ----
// self-checking bench for the channel maintenance block
// assumes the backplane model on the serial side and a short tick
`timescale 1ns/1ps
module tb;
	import ecm_pkg::*;
	localparam int TL = 50;
	logic        clk, nrst, busClk, busFrame_n, ctlInA, ctlInB, dIn;
	logic        statOut, dOut, frameSync, regWr, regRd, irq;
	logic [3:0]  regAddr;
	logic [7:0]  regWrData, regRdData, st, tx0Prev;
	logic [7:0]  txd [32];
	ecm_rxslot_s rxSlot;
	ecm_stat_s   statWords;
	ecm_txslot_s txSlot;
	int          num_errors, n_compared, i;

	ecm_channel_maint #(.TICK_LEN(TL)) DUT (.clk(clk), .nrst(nrst),
		.busClk(busClk), .busFrame_n(busFrame_n),
		.controlInStreamA(ctlInA), .controlInStreamB(ctlInB),
		.dataInStream(dIn), .statusOutStream(statOut),
		.dataOutStream(dOut), .rxSlot(rxSlot), .frameSync(frameSync),
		.statWords(statWords), .txSlot(txSlot), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .irq(irq));
	ecm_backplane_model bp (.busClk(busClk), .busFrame_n(busFrame_n),
		.controlInStreamA(ctlInA), .controlInStreamB(ctlInB),
		.dataInStream(dIn), .statusOutStream(statOut),
		.dataOutStream(dOut));

	// core clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// keep the last word of every transmit slot, and the ch0 before it
	always @(posedge clk)
		if (txSlot.valid === 1'b1) begin
			txd[txSlot.num] <= txSlot.data;
			if (txSlot.num == 5'h00)
				tx0Prev <= txd[0];
		end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 st = regRdData;
	endtask
	task automatic slot(input logic [4:0] n, input logic [7:0] d,
		input logic [3:0] f, input logic al);
		@(posedge clk);
		rxSlot <= {1'b1, n, d, f, al};
		@(posedge clk);
		rxSlot.valid <= 1'b0;
	endtask
	// two frame ends guarantee one whole frame after the change
	task automatic waitFr();
		int f0;
		f0 = bp.frames;
		wait (bp.frames >= f0 + 2);
	endtask
	task automatic irqIs(input logic v);
		repeat (2) @(posedge clk);
		#1 check({7'h00, irq}, {7'h00, v});
	endtask
	task automatic done(input string name);
		$display("test %s done: %0d compared", name, n_compared);
	endtask
	task automatic finish_test();
		$display("counts: %0d compared, %0d errors", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// a hang counts as a mismatch and ends the run the usual way
	initial begin
		repeat (95000) @(posedge clk);
		num_errors++;
		$display("Error at %0t: watchdog seen %h expected %h", $time, 0, 1);
		finish_test();
	end

	// main sequence
	initial begin
		num_errors = 0;
		n_compared = 0;
		nrst = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 4'h0;
		regWrData = 8'h00;
		frameSync = 1'b0;
		rxSlot = '0;
		statWords = {8'ha5, 8'h13, 8'h14, 8'h21};
		for (i = 0; i < 32; i++) begin
			bp.ctlA[i] = 8'h00;
			bp.ctlB[i] = {4'h8, 4'(i)};
			bp.dataIn[i] = 8'h3c;
		end
		bp.ctlA[5] = 8'h36;
		bp.ctlB[16] = 8'h9b;
		bp.ctlB[17] = 8'h5f;
		bp.dataIn[5] = 8'ha5;
		bp.dataIn[6] = 8'ha5;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;

		rd(REG_CTRL);  check(st, 8'h00);
		rd(REG_STAT);  check(st, 8'h00);
		rd(REG_IRQST); check(st, 8'h00);
		rd(REG_IRQMS); check(st, 8'h00);
		wr(4'h9, 8'hff);
		rd(4'h9);      check(st, 8'h00);
		wr(REG_IRQMS, 8'h03);
		rd(REG_IRQMS); check(st, 8'h03);
		done("registers");

		// control words must have arrived before the gained slot lands
		waitFr();
		slot(5'h05, 8'ha5, 4'h0, 1'b0);
		slot(5'h06, 8'ha5, 4'h0, 1'b0);
		waitFr();
		check(bp.statCh[0], 8'hff);
		check(bp.statCh[17], 8'h00);
		check(bp.statCh[18], 8'h85);
		check(bp.statCh[19], 8'h13);
		check(bp.statCh[20], 8'h14);
		check(bp.statCh[21], 8'h21);
		check(bp.statCh[31], 8'h00);
		check(bp.dataCh[5], 8'ha5);
		check({7'h00, bp.dataCh[6] !== 8'ha5}, 8'h01);
		check(txd[5], 8'ha5);
		check({7'h00, txd[6] !== 8'ha5}, 8'h01);
		check({7'h00, {tx0Prev, txd[0]} == 16'h9b5f ||
			{tx0Prev, txd[0]} == 16'h5f9b}, 8'h01);
		check(txd[16] & 8'hf0, 8'h80);
		wr(REG_CTRL, 8'h01);
		waitFr();
		check(txd[16], 8'h3c);
		done("streams");

		// reset leaves no guard running, so the 16th error acts at once
		bp.ctlA[15] = 8'hff;
		repeat (7000) @(posedge clk);
		frameSync <= 1'b1;
		repeat (15) slot(5'h00, 8'h00, 4'h0, 1'b1);
		repeat (8) slot(5'h00, 8'h9b, 4'h0, 1'b1);
		repeat (8) slot(5'h00, 8'h00, 4'h1, 1'b0);
		frameSync <= 1'b0;
		repeat (8) slot(5'h00, 8'h00, 4'h0, 1'b1);
		frameSync <= 1'b1;
		rd(REG_STAT);  check(st & 8'h02, 8'h00);
		slot(5'h00, 8'h1a, 4'h0, 1'b1);
		repeat (4) @(posedge clk);
		rd(REG_STAT);  check(st & 8'h03, 8'h03);
		rd(REG_IRQST); check(st & 8'h03, 8'h03);
		wr(REG_IRQMS, 8'h00);
		irqIs(1'b0);
		wr(REG_IRQMS, 8'h03);
		irqIs(1'b1);
		wr(REG_IRQST, 8'h03);
		irqIs(1'b0);
		rd(REG_IRQST); check(st & 8'h03, 8'h00);
		repeat (16) slot(5'h00, 8'h00, 4'h0, 1'b1);
		repeat (5800) @(posedge clk);
		rd(REG_STAT);  check(st & 8'h02, 8'h02);
		for (i = 0; i < 600 && st[1]; i++)
			rd(REG_STAT);
		check(st & 8'h02, 8'h00);
		done("error flag");

		// debounce off: accepted at once; then turned on, and later turned off again for bit A only
		slot(5'h10, 8'h5a, 4'h3, 1'b0);
		bp.ctlA[15] = 8'hf0;
		waitFr();
		check(bp.statCh[3], 8'h5a);
		rd(REG_STAT);  check(st & 8'h09, 8'h09);
		rd(REG_IRQST); check(st & 8'h04, 8'h04);
		repeat (2) slot(5'h10, 8'h96, 4'h3, 1'b0);
		waitFr();
		check(bp.statCh[3], 8'h5a);
		slot(5'h10, 8'h69, 4'h3, 1'b0);
		repeat (2) slot(5'h10, 8'h96, 4'h3, 1'b0);
		waitFr();
		check(bp.statCh[3], 8'h5a);
		repeat (2) slot(5'h10, 8'h96, 4'h3, 1'b0);
		bp.ctlA[15] = 8'hf1;
		waitFr();
		check(bp.statCh[3], 8'h96);
		slot(5'h10, 8'h69, 4'h3, 1'b0);
		waitFr();
		check(bp.statCh[3], 8'h1e);
		done("signalling");

		frameSync <= 1'b0;
		repeat (10) @(posedge clk);
		rd(REG_STAT);  check(st & 8'h0d, 8'h0c);
		repeat (180) @(posedge clk);
		rd(REG_STAT);  check(st & 8'h04, 8'h04);
		repeat (160) @(posedge clk);
		rd(REG_STAT);  check(st & 8'h0c, 8'h00);
		rd(REG_IRQST); check(st & 8'h02, 8'h02);
		waitFr();
		check(bp.statCh[3], 8'hff);
		done("hold-over");
		finish_test();
	end
endmodule // tb
